// ### logic/dir_router.sv
/*
 * Digital input signal router: input polarity, multifunction and shared
 * terminal enables, per-function source selection, APB register file.
 * Assumes terminal pins are asynchronous, status inputs are on core_clk,
 * and an APB3 master on core_clk.
 */
`timescale 1ns/1ps

module dir_router
	import dir_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Terminal pins
	input wire logic safe_enable_a,
	input wire logic safe_enable_b,
	input wire logic digital_input_1,
	input wire logic digital_input_2,
	input wire logic shared_terminal_input,
	input wire logic digital_input_4,
	input wire logic digital_input_5,
	input wire logic multifunction_input_1,
	input wire logic multifunction_input_2,
	// Drive status
	input wire logic drive_ready,
	input wire logic drive_fault,
	input wire logic freq_reached,
	input wire logic out_freq_present,
	input wire logic drive_overload,
	input wire logic critical_warning,
	input wire logic [31:0] warn_vector,
	input wire logic [15:0] stator_freq,
	// Routed control
	output logic [NUM_FUNC-1:0] func_ctrl,
	output logic drive_enable,
	output logic start_cw_cmd,
	output logic start_ccw_cmd,
	output logic run_signal
);

	dir_state_t r;
	dir_state_t next_r;
	logic [NUM_PIN-1:0] pins;
	logic std_act;
	logic in1_loc;
	logic in2_loc;
	logic shared_loc;
	logic in4_loc;
	logic in5_loc;
	logic multifunction_input_1_loc;
	logic multifunction_input_2_loc;
	logic en_loc;
	logic [7:0] src;
	logic masked_warn;
	logic above_thresh;
	logic [NUM_FUNC-1:0] routed;
	logic setup;
	logic access;
	logic [31:0] rd_val;
	logic rd_err;
	logic [7:0] sel_ofs;

	assign pins = {multifunction_input_2, multifunction_input_1,
		digital_input_5, digital_input_4, shared_terminal_input,
		digital_input_2, digital_input_1, safe_enable_b, safe_enable_a};

	// ****************************************************************
	// Input conditioning
	// ****************************************************************
	assign std_act = (r.polarity == POL_HIGH_ACTIVE);
	assign in1_loc = r.sync2[PIN_IN1] ~^ std_act;
	assign in2_loc = r.sync2[PIN_IN2] ~^ std_act;
	assign in4_loc = r.sync2[PIN_IN4] ~^ std_act;
	assign in5_loc = r.sync2[PIN_IN5] ~^ std_act;
	assign shared_loc = (r.term_mode == TERM_INPUT) &&
		(r.sync2[PIN_SHARED] ~^ std_act);
	assign multifunction_input_1_loc = (r.multifunction_input_1_mode == MFI_DIG_LOW) ? !r.sync2[PIN_MULTIFUNCTION_INPUT_1] :
		(r.multifunction_input_1_mode == MFI_DIG_HIGH) ? r.sync2[PIN_MULTIFUNCTION_INPUT_1] :
		1'b0;
	assign multifunction_input_2_loc = (r.multifunction_input_2_mode == MFI_DIG_LOW) ? !r.sync2[PIN_MULTIFUNCTION_INPUT_2] :
		(r.multifunction_input_2_mode == MFI_DIG_HIGH) ? r.sync2[PIN_MULTIFUNCTION_INPUT_2] :
		1'b0;
	assign en_loc = r.sync2[PIN_EN_A] && r.sync2[PIN_EN_B];

	// Remote mode replaces every terminal source in src; run still uses the terminal enable pair
	assign src = r.remote ? r.remote_val : {multifunction_input_2_loc, multifunction_input_1_loc,
		in5_loc, in4_loc, shared_loc, in2_loc, in1_loc,
		en_loc};

	assign masked_warn = |(warn_vector & r.warn_mask);
	assign above_thresh = stator_freq > r.freq_thresh;

	// ****************************************************************
	// Source selection per function
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_FUNC; g++)
		begin : gen_route
			always_comb
			begin
				unique case (r.sel[g])
					SEL_ON: routed[g] = 1'b1;
					SEL_OFF: routed[g] = 1'b0;
					SEL_ENABLE: routed[g] = src[0];
					SEL_IN1: routed[g] = src[1];
					SEL_IN2: routed[g] = src[2];
					SEL_SHARED: routed[g] = src[3];
					SEL_IN4: routed[g] = src[4];
					SEL_IN5: routed[g] = src[5];
					SEL_MULTIFUNCTION_INPUT_1: routed[g] = src[6];
					SEL_MULTIFUNCTION_INPUT_2: routed[g] = src[7];
					SEL_WARN_MASK: routed[g] = masked_warn;
					SEL_READY: routed[g] = drive_ready;
					SEL_RUN: routed[g] = r.run;
					SEL_ERROR: routed[g] = drive_fault;
					SEL_FREQ_REACHED: routed[g] = freq_reached;
					SEL_SET_FREQ: routed[g] = above_thresh;
					SEL_OVERLOAD: routed[g] = drive_overload;
					SEL_GEN_WARN: routed[g] = critical_warning;
					default: routed[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	// ****************************************************************
	// APB decode
	// ****************************************************************
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign sel_ofs = paddr - OFS_SEL0;

	always_comb
	begin
		rd_val = 32'h0;
		rd_err = 1'b0;
		if (paddr == OFS_CTRL)
		begin
			rd_val[CTRL_POL_BIT] = r.polarity;
			rd_val[CTRL_REMOTE_BIT] = r.remote;
			rd_val[CTRL_MULTIFUNCTION_INPUT_1_LSB +: 3] = r.multifunction_input_1_mode;
			rd_val[CTRL_MULTIFUNCTION_INPUT_2_LSB +: 3] = r.multifunction_input_2_mode;
			rd_val[CTRL_TERM_LSB +: 3] = r.term_mode;
		end
		else if (paddr == OFS_REMOTE)
			rd_val[7:0] = r.remote_val;
		else if (paddr == OFS_WARN_MASK)
			rd_val = r.warn_mask;
		else if (paddr == OFS_FREQ_THRESH)
			rd_val[15:0] = r.freq_thresh;
		else if (paddr >= OFS_SEL0 && paddr < OFS_STATUS &&
			paddr[1:0] == 2'h0)
			rd_val[7:0] = r.sel[sel_ofs[3:2]];
		else if (paddr == OFS_STATUS)
		begin
			rd_val[NUM_PIN-1:0] = r.sync2;
			rd_val[STAT_FUNC_LSB +: NUM_FUNC] = r.func;
			rd_val[STAT_RUN_BIT] = r.run;
			rd_val[STAT_EN_BIT] = r.drive_en;
		end
		else
			rd_err = 1'b1;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_r = r;
		next_r.sync1 = pins;
		next_r.sync2 = r.sync1;
		next_r.func = routed;
		next_r.drive_en = src[0];
		next_r.start_cw = routed[0] && src[0];
		next_r.start_ccw = routed[1] && src[0];
		next_r.run = en_loc && (r.func[0] || r.func[1]) &&
			out_freq_present;
		if (setup)
		begin
			next_r.prdata = pwrite ? 32'h0 : rd_val;
			next_r.pslverr = rd_err || (pwrite && paddr == OFS_STATUS);
		end
		if (access && pwrite && !r.pslverr)
		begin
			if (paddr == OFS_CTRL)
			begin
				next_r.polarity = pwdata[CTRL_POL_BIT];
				next_r.remote = pwdata[CTRL_REMOTE_BIT];
				next_r.multifunction_input_1_mode = pwdata[CTRL_MULTIFUNCTION_INPUT_1_LSB +: 3];
				next_r.multifunction_input_2_mode = pwdata[CTRL_MULTIFUNCTION_INPUT_2_LSB +: 3];
				next_r.term_mode = pwdata[CTRL_TERM_LSB +: 3];
			end
			else if (paddr == OFS_REMOTE)
				next_r.remote_val = pwdata[7:0];
			else if (paddr == OFS_WARN_MASK)
				next_r.warn_mask = pwdata;
			else if (paddr == OFS_FREQ_THRESH)
				next_r.freq_thresh = pwdata[15:0];
			else if (paddr >= OFS_SEL0 && paddr < OFS_STATUS)
				next_r.sel[sel_ofs[3:2]] = pwdata[7:0];
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.polarity <= RST_POLARITY;
			r.multifunction_input_1_mode <= RST_MULTIFUNCTION_INPUT_1_MODE;
			r.multifunction_input_2_mode <= RST_MULTIFUNCTION_INPUT_2_MODE;
			r.term_mode <= RST_TERM_MODE;
			r.sel <= {NUM_FUNC{RST_SEL}};
		end
		else
			r <= next_r;
	end

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = r.pslverr && access;
	assign func_ctrl = r.func;
	assign drive_enable = r.drive_en;
	assign start_cw_cmd = r.start_cw;
	assign start_ccw_cmd = r.start_ccw;
	assign run_signal = r.run;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	property p_low_active;
		!r.remote && r.sel[2] == SEL_IN1 && r.polarity == POL_LOW_ACTIVE
		&& !r.sync2[PIN_IN1] |=> r.func[2];
	endproperty
	a_low_active: assert property (p_low_active)
		else $error("low active input not routed");

	property p_high_active;
		!r.remote && r.sel[2] == SEL_IN1 && r.polarity == POL_HIGH_ACTIVE
		|=> r.func[2] == $past(r.sync2[PIN_IN1]);
	endproperty
	a_high_active: assert property (p_high_active)
		else $error("high active input not routed");

	property p_multifunction_input_1_off;
		!r.remote && r.sel[2] == SEL_MULTIFUNCTION_INPUT_1 && r.multifunction_input_1_mode != MFI_DIG_LOW &&
		r.multifunction_input_1_mode != MFI_DIG_HIGH |=> !r.func[2];
	endproperty
	a_multifunction_input_1_off: assert property (p_multifunction_input_1_off)
		else $error("analog mode input seen as digital");

	property p_term_out;
		!r.remote && r.sel[2] == SEL_SHARED && r.term_mode != TERM_INPUT
		|=> !r.func[2];
	endproperty
	a_term_out: assert property (p_term_out)
		else $error("shared terminal routed while output");

	property p_const;
		r.sel[2] == SEL_ON |=> r.func[2];
	endproperty
	a_const: assert property (p_const)
		else $error("constant on not held");

	property p_off;
		r.sel[2] == SEL_OFF |=> !r.func[2];
	endproperty
	a_off: assert property (p_off)
		else $error("constant off asserted");

	property p_remote;
		r.remote && r.sel[2] == SEL_IN1
		|=> r.func[2] == $past(r.remote_val[RV_IN1]);
	endproperty
	a_remote: assert property (p_remote)
		else $error("remote value not routed");

	property p_start_gate;
		start_cw_cmd || start_ccw_cmd |-> $past(src[0]);
	endproperty
	a_start_gate: assert property (p_start_gate)
		else $error("start without drive enable");

	property p_set_freq;
		r.sel[2] == SEL_SET_FREQ |=>
		r.func[2] == ($past(stator_freq) > $past(r.freq_thresh));
	endproperty
	a_set_freq: assert property (p_set_freq)
		else $error("setting frequency compare wrong");

	property p_run;
		r.run |-> $past(en_loc) && $past(out_freq_present);
	endproperty
	a_run: assert property (p_run)
		else $error("run without enables or frequency");

	c_remote: cover property (r.remote && r.func[2]);
	c_start: cover property (start_cw_cmd ##1 run_signal);
	c_warn: cover property (r.sel[2] == SEL_WARN_MASK ##1 r.func[2]);
	c_low: cover property (!r.polarity && r.func[2]);

endmodule

// ### common/dir_pkg.sv
/*
 * Package for the digital input signal router: register map, reset
 * values, source selection codes and the state record of the block.
 * Assumes a 32-bit APB register bus and one core clock.
 */
package dir_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_FUNC = 4;
	localparam int NUM_PIN = 9;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_REMOTE = 8'h04;
	localparam logic [7:0] OFS_WARN_MASK = 8'h08;
	localparam logic [7:0] OFS_FREQ_THRESH = 8'h0c;
	localparam logic [7:0] OFS_SEL0 = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// ****************************************************************
	// Control and status register fields
	// ****************************************************************
	localparam int CTRL_POL_BIT = 0;
	localparam int CTRL_REMOTE_BIT = 1;
	localparam int CTRL_MULTIFUNCTION_INPUT_1_LSB = 4;
	localparam int CTRL_MULTIFUNCTION_INPUT_2_LSB = 8;
	localparam int CTRL_TERM_LSB = 12;
	localparam int STAT_FUNC_LSB = 16;
	localparam int STAT_RUN_BIT = 20;
	localparam int STAT_EN_BIT = 21;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic RST_POLARITY = 1'b1;
	localparam logic [2:0] RST_MULTIFUNCTION_INPUT_1_MODE = 3'h0;
	localparam logic [2:0] RST_MULTIFUNCTION_INPUT_2_MODE = 3'h3;
	localparam logic [2:0] RST_TERM_MODE = 3'h0;
	localparam logic [7:0] RST_SEL = 8'h07;

	// ****************************************************************
	// Mode codes
	// ****************************************************************
	localparam logic POL_LOW_ACTIVE = 1'b0;
	localparam logic POL_HIGH_ACTIVE = 1'b1;
	localparam logic [2:0] MFI_DIG_LOW = 3'h3;
	localparam logic [2:0] MFI_DIG_HIGH = 3'h4;
	localparam logic [2:0] TERM_INPUT = 3'h0;

	// ****************************************************************
	// Source selection codes
	// ****************************************************************
	localparam logic [7:0] SEL_ON = 8'h06;
	localparam logic [7:0] SEL_OFF = 8'h07;
	localparam logic [7:0] SEL_ENABLE = 8'h46;
	localparam logic [7:0] SEL_IN1 = 8'h47;
	localparam logic [7:0] SEL_IN2 = 8'h48;
	localparam logic [7:0] SEL_SHARED = 8'h49;
	localparam logic [7:0] SEL_IN4 = 8'h4a;
	localparam logic [7:0] SEL_IN5 = 8'h4b;
	localparam logic [7:0] SEL_MULTIFUNCTION_INPUT_1 = 8'h4c;
	localparam logic [7:0] SEL_MULTIFUNCTION_INPUT_2 = 8'h4d;
	localparam logic [7:0] SEL_WARN_MASK = 8'h9d;
	localparam logic [7:0] SEL_READY = 8'ha0;
	localparam logic [7:0] SEL_RUN = 8'ha1;
	localparam logic [7:0] SEL_ERROR = 8'ha2;
	localparam logic [7:0] SEL_FREQ_REACHED = 8'ha3;
	localparam logic [7:0] SEL_SET_FREQ = 8'ha4;
	localparam logic [7:0] SEL_OVERLOAD = 8'ha5;
	localparam logic [7:0] SEL_GEN_WARN = 8'ha9;

	// ****************************************************************
	// Pin index in the synchroniser vector
	// ****************************************************************
	localparam int PIN_EN_A = 0;
	localparam int PIN_EN_B = 1;
	localparam int PIN_IN1 = 2;
	localparam int PIN_IN2 = 3;
	localparam int PIN_SHARED = 4;
	localparam int PIN_IN4 = 5;
	localparam int PIN_IN5 = 6;
	localparam int PIN_MULTIFUNCTION_INPUT_1 = 7;
	localparam int PIN_MULTIFUNCTION_INPUT_2 = 8;

	// Remote value bits
	localparam int RV_ENABLE = 0;
	localparam int RV_IN1 = 1;
	localparam int RV_SHARED = 3;
	localparam int RV_MULTIFUNCTION_INPUT_1 = 6;

	// ****************************************************************
	// State record
	// ****************************************************************
	typedef struct packed {
		logic [NUM_PIN-1:0] sync1;
		logic [NUM_PIN-1:0] sync2;
		logic polarity;
		logic remote;
		logic [2:0] multifunction_input_1_mode;
		logic [2:0] multifunction_input_2_mode;
		logic [2:0] term_mode;
		logic [7:0] remote_val;
		logic [31:0] warn_mask;
		logic [15:0] freq_thresh;
		logic [NUM_FUNC-1:0][7:0] sel;
		logic [NUM_FUNC-1:0] func;
		logic drive_en;
		logic start_cw;
		logic start_ccw;
		logic run;
		logic [31:0] prdata;
		logic pslverr;
	} dir_state_t;

endpackage

// ### tb/dir_switches.sv
/*
 * Model of the external switches and wiring at the terminal pins.
 * Assumes the bench sets the wanted levels just after a clock edge.
 */
`timescale 1ns/1ps
module dir_switches
(
	// Wanted levels
	input wire logic [8:0] lvl,
	// Terminal pins
	output logic safe_enable_a,
	output logic safe_enable_b,
	output logic digital_input_1,
	output logic digital_input_2,
	output logic shared_terminal_input,
	output logic digital_input_4,
	output logic digital_input_5,
	output logic multifunction_input_1,
	output logic multifunction_input_2
);
	// Enable pair and start contacts each follow their own bit of lvl
	assign {multifunction_input_2, multifunction_input_1, digital_input_5,
		digital_input_4, shared_terminal_input, digital_input_2,
		digital_input_1, safe_enable_b, safe_enable_a} = lvl;
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench of the digital input signal router.
 * Assumes dir_pkg and the switch model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("mismatch %0t: got %h exp %h", $time, g, e); \
		end \
	end
module tb
	import dir_pkg::*;
;
	typedef struct packed {
		logic [7:0] sel;
		logic [15:0] ctrl;
		logic [7:0] rem;
		logic [8:0] pins;
		logic [7:0] sts;
		logic exp;
	} dir_row_t;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [8:0] lvl = 9'h000;
	logic [5:0] sts = 6'h00;
	logic [31:0] warn_vector = 32'h0;
	logic [15:0] stator_freq = 16'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] func_ctrl;
	logic drive_enable;
	logic start_cw_cmd;
	logic start_ccw_cmd;
	logic run_signal;
	wire [8:0] pin;
	logic [31:0] q;
	logic e;
	int errors = 0;
	int compares = 0;
	// Stimulus rows; sts[6] masked warning, sts[7] stator above threshold
	dir_row_t rows [$] = '{
		'{SEL_ON,16'h0301,8'h00,9'h000,8'h00,1'b1},
		'{SEL_OFF,16'h0301,8'h00,9'h1ff,8'hff,1'b0},
		'{SEL_ENABLE,16'h0301,8'h00,9'h003,8'h00,1'b1},
		'{SEL_ENABLE,16'h0301,8'h00,9'h001,8'h00,1'b0},
		'{SEL_ENABLE,16'h0303,8'h01,9'h000,8'h00,1'b1},
		'{SEL_IN1,16'h0301,8'h00,9'h004,8'h00,1'b1},
		'{SEL_IN1,16'h0300,8'h00,9'h004,8'h00,1'b0},
		'{SEL_IN1,16'h0300,8'h00,9'h000,8'h00,1'b1},
		'{SEL_IN1,16'h0303,8'h02,9'h000,8'h00,1'b1},
		'{SEL_IN2,16'h0301,8'h00,9'h008,8'h00,1'b1},
		'{SEL_IN4,16'h0301,8'h00,9'h020,8'h00,1'b1},
		'{SEL_IN5,16'h0301,8'h00,9'h040,8'h00,1'b1},
		'{SEL_IN5,16'h0303,8'h20,9'h000,8'h00,1'b1},
		'{SEL_IN2,16'h0303,8'h00,9'h008,8'h00,1'b0},
		'{SEL_SHARED,16'h0301,8'h00,9'h010,8'h00,1'b1},
		'{SEL_SHARED,16'h1301,8'h00,9'h010,8'h00,1'b0},
		'{SEL_SHARED,16'h1303,8'h08,9'h000,8'h00,1'b1},
		'{SEL_MULTIFUNCTION_INPUT_1,16'h0301,8'h00,9'h080,8'h00,1'b0},
		'{SEL_MULTIFUNCTION_INPUT_1,16'h0341,8'h00,9'h080,8'h00,1'b1},
		'{SEL_MULTIFUNCTION_INPUT_1,16'h0331,8'h00,9'h000,8'h00,1'b1},
		'{SEL_MULTIFUNCTION_INPUT_2,16'h0301,8'h00,9'h000,8'h00,1'b1},
		'{SEL_MULTIFUNCTION_INPUT_2,16'h0401,8'h00,9'h100,8'h00,1'b1},
		'{SEL_MULTIFUNCTION_INPUT_2,16'h0501,8'h00,9'h100,8'h00,1'b0},
		'{SEL_MULTIFUNCTION_INPUT_1,16'h0303,8'h40,9'h000,8'h00,1'b1},
		'{SEL_WARN_MASK,16'h0301,8'h00,9'h000,8'h40,1'b1},
		'{SEL_WARN_MASK,16'h0301,8'h00,9'h000,8'hbf,1'b0},
		'{SEL_READY,16'h0301,8'h00,9'h000,8'h01,1'b1},
		'{SEL_RUN,16'h0301,8'h00,9'h007,8'h08,1'b1},
		'{SEL_RUN,16'h0301,8'h00,9'h003,8'h08,1'b0},
		'{SEL_RUN,16'h0301,8'h00,9'h007,8'h00,1'b0},
		'{SEL_ERROR,16'h0301,8'h00,9'h000,8'h02,1'b1},
		'{SEL_FREQ_REACHED,16'h0301,8'h00,9'h000,8'h04,1'b1},
		'{SEL_SET_FREQ,16'h0301,8'h00,9'h000,8'h80,1'b1},
		'{SEL_SET_FREQ,16'h0301,8'h00,9'h000,8'h00,1'b0},
		'{SEL_OVERLOAD,16'h0301,8'h00,9'h000,8'h10,1'b1},
		'{SEL_GEN_WARN,16'h0301,8'h00,9'h000,8'h20,1'b1}
	};

	always #25 core_clk = ~core_clk;

	dir_switches i_sw (.lvl(lvl), .safe_enable_a(pin[0]),
		.safe_enable_b(pin[1]), .digital_input_1(pin[2]),
		.digital_input_2(pin[3]), .shared_terminal_input(pin[4]),
		.digital_input_4(pin[5]), .digital_input_5(pin[6]),
		.multifunction_input_1(pin[7]), .multifunction_input_2(pin[8]));

	dir_router i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .safe_enable_a(pin[0]),
		.safe_enable_b(pin[1]), .digital_input_1(pin[2]),
		.digital_input_2(pin[3]), .shared_terminal_input(pin[4]),
		.digital_input_4(pin[5]), .digital_input_5(pin[6]),
		.multifunction_input_1(pin[7]), .multifunction_input_2(pin[8]),
		.drive_ready(sts[0]), .drive_fault(sts[1]),
		.freq_reached(sts[2]), .out_freq_present(sts[3]),
		.drive_overload(sts[4]), .critical_warning(sts[5]),
		.warn_vector(warn_vector), .stator_freq(stator_freq),
		.func_ctrl(func_ctrl), .drive_enable(drive_enable),
		.start_cw_cmd(start_cw_cmd), .start_ccw_cmd(start_ccw_cmd),
		.run_signal(run_signal));

	// ****************************************************************
	// Bus cycle and closing report
	// ****************************************************************
	task automatic stop_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b1, OFS_WARN_MASK, 32'h2, q, e);
		apb(1'b1, OFS_FREQ_THRESH, 32'h0100, q, e);
		apb(1'b1, 8'h14, {24'h0, SEL_IN1}, q, e);
		foreach (rows[i])
		begin
			apb(1'b1, OFS_CTRL, {16'h0, rows[i].ctrl}, q, e);
			apb(1'b1, OFS_REMOTE, {24'h0, rows[i].rem}, q, e);
			apb(1'b1, 8'h18, {24'h0, rows[i].sel}, q, e);
			lvl <= rows[i].pins;
			sts <= rows[i].sts[5:0];
			warn_vector <= {30'h0, rows[i].sts[6], 1'b1};
			stator_freq <= rows[i].sts[7] ? 16'h0101 : 16'h0100;
			repeat (8) @(posedge core_clk);
			`CHK(func_ctrl[2], rows[i].exp)
		end
		// Start held back without enable
		apb(1'b1, OFS_CTRL, 32'h0301, q, e);
		apb(1'b1, OFS_SEL0, {24'h0, SEL_IN1}, q, e);
		sts <= 6'h08;
		lvl <= 9'h004;
		repeat (8) @(posedge core_clk);
		`CHK(start_ccw_cmd, 1'b0)
		`CHK(start_cw_cmd, 1'b0)
		`CHK(run_signal, 1'b0)
		lvl <= 9'h007;
		repeat (8) @(posedge core_clk);
		`CHK(start_ccw_cmd, 1'b1)
		`CHK(start_cw_cmd, 1'b1)
		`CHK(run_signal, 1'b1)
		`CHK(func_ctrl, 4'h3)
		`CHK(drive_enable, 1'b1)
		apb(1'b1, OFS_CTRL, 32'hffff_ffff, q, e);
		apb(1'b0, OFS_CTRL, 32'h0, q, e);
		`CHK(q, 32'h0000_7773)
		apb(1'b0, 8'h24, 32'h0, q, e);
		`CHK({e, q}, 33'h1_0000_0000)
		// All remote sources on, so reset has something to clear
		apb(1'b1, OFS_REMOTE, 32'hff, q, e);
		repeat (4) @(posedge core_clk);
		`CHK({func_ctrl, drive_enable, run_signal}, 6'h0f)
		// Second reset in mid-run
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		`CHK({func_ctrl, drive_enable, run_signal}, 6'h00)
		rst_n <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0, q, e);
		`CHK(q, 32'h0000_0301)
		apb(1'b0, OFS_SEL0, 32'h0, q, e);
		`CHK(q[7:0], SEL_OFF)
		stop_test();
	end
endmodule
